// *** pcg_consts.vh ***
// Register indices, field positions and reset values of the clock generator
// How it works
// - Four peripheral clocks pick full-rate or divided source; six gate bits enable clocks
// - PCM clock runs only while enabled, divided by 12-bit integer from chosen source
// - Fraction pattern: leftmost one sets denominator, ones count numerator, spread over period
// - PDM role bit: zero is slave mode, one is master mode
// - PDM clock runs only while enabled, divided by 8-bit divisor
// - Rate converter clock runs only while enabled, divided by 8-bit divisor
// - USB pad power follows USB enable, or is forced on by bit zero
// - Pull-up switch A follows controller while USB enabled, or is forced off
// - Pull-up switch B follows controller while USB enabled, or is forced on
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH

// Register indices; byte address is four times the index
`define PCG_IDX_PER_SEL_GATE 32'h50001c04
`define PCG_IDX_PCM_DIV      32'h50001c40
`define PCG_IDX_PCM_FRAC     32'h50001c42
`define PCG_IDX_PDM_DIVISOR      32'h50001c44
`define PCG_IDX_RC_DIV       32'h50001c46
`define PCG_IDX_USB_PAD      32'h50001c4a

// Writable bits of each register
`define PCG_MASK_PER_SEL_GATE 16'h0f3f
`define PCG_MASK_PCM_DIV      16'h3fff
`define PCG_MASK_PCM_FRAC     16'hffff
`define PCG_MASK_PDM_DIVISOR      16'h03ff
`define PCG_MASK_RC_DIV       16'h01ff
`define PCG_MASK_USB_PAD      16'h0007

// Reset values
`define PCG_RST_VALUE 16'h0000

// Peripheral select / gate fields
`define PCG_SEL_LSB  8
`define PCG_SEL_MSB  11
`define PCG_GATE_LSB 0
`define PCG_GATE_MSB 5

// PCM divider fields
`define PCG_PCM_SRC_BIT 13
`define PCG_PCM_EN_BIT  12
`define PCG_PCM_DIV_MSB 11

// PDM and rate converter fields
`define PCG_PDM_ROLE_BIT 9
`define PCG_DIV8_EN_BIT  8
`define PCG_DIV8_MSB     7

// USB pad fields
`define PCG_USB_PWR_BIT   0
`define PCG_USB_A_OFF_BIT 1
`define PCG_USB_B_ON_BIT  2

`endif

// *** pcg_top.v ***
// Peripheral clock generator: APB registers, clock gates, dividers, USB pads
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "pcg_consts.vh"

module pcg_clkdiv #(
    parameter DW = 12,
    parameter FW = 16
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rstn,
    // Control
    input  wire          en,
    input  wire          tick,
    input  wire [DW-1:0] div,
    input  wire [FW-1:0] frac,
    // Generated clock
    output reg           clk_q
);
    reg  [DW:0]   cnt_q;
    reg  [3:0]    ptr_q;
    reg  [3:0]    msb;
    reg  [DW:0]   len;
    wire          run;
    integer       i;

    // Once enable drops, finish the high phase so no runt pulse leaves
    assign run = en | clk_q;

    // Leftmost one of the pattern fixes the denominator
    always @* begin
        msb = 4'h0;
        for (i = 0; i < FW; i = i + 1) begin
            if (frac[i]) begin
                msb = i[3:0];
            end
        end
    end

    // Half period length, stretched by one tick where the pattern holds a one
    always @* begin
        len = {1'b0, div};
        if (div == {DW{1'b0}}) begin
            len = {{DW{1'b0}}, 1'b1};
        end
        if (frac[ptr_q]) begin
            len = len + {{DW{1'b0}}, 1'b1};
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= {(DW+1){1'b0}};
            ptr_q <= 4'h0;
            clk_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= {(DW+1){1'b0}};
            ptr_q <= msb;
            clk_q <= 1'b0;
        end else if (tick) begin
            if (cnt_q + {{DW{1'b0}}, 1'b1} >= len) begin
                cnt_q <= {(DW+1){1'b0}};
                clk_q <= ~clk_q;
                if (ptr_q == 4'h0) begin
                    ptr_q <= msb;
                end else begin
                    ptr_q <= ptr_q - 4'h1;
                end
            end else begin
                cnt_q <= cnt_q + {{DW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // pcg_clkdiv

module pcg_top #(
    parameter AW = 32
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rstn,
    // APB slave
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [AW-1:0] paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    // Source clock ticks
    input  wire          full_rate_tick,
    input  wire          divided_tick,
    // Peripheral clock ticks: uart, spi, i2c, quad, infrared, keyscan
    output reg  [5:0]    periph_tick,
    output reg           adc_tick,
    // Generated clocks
    output wire          pcm_clk,
    output wire          pdm_clk,
    output wire          rate_converter_clk,
    output reg           pdm_role_select,
    // USB controller side
    input  wire          usb_enabled,
    input  wire          usb_ctrl_pullup_a,
    input  wire          usb_ctrl_pullup_b,
    // USB pad side
    output reg           usb_pad_power,
    output reg           pullup_switch_a,
    output reg           pullup_switch_b
);
    reg  [15:0] per_q;
    reg  [15:0] pcm_div_q;
    reg  [15:0] pcm_frac_q;
    reg  [15:0] pdm_divisor_q;
    reg  [15:0] rc_div_q;
    reg  [15:0] usb_q;
    reg  [15:0] rd_val;
    reg         hit;
    wire [7:0]  idx;
    wire        access;
    wire        wr_en;
    wire [15:0] wd;
    wire [3:0]  sel_tick;
    wire [5:0]  src_tick;
    wire        pcm_tick;
    genvar      g;

    // Low byte of each register index, compared against paddr[9:2]
    localparam [31:0] FULL_PER  = `PCG_IDX_PER_SEL_GATE;
    localparam [31:0] FULL_PCM  = `PCG_IDX_PCM_DIV;
    localparam [31:0] FULL_FRAC = `PCG_IDX_PCM_FRAC;
    localparam [31:0] FULL_PDM  = `PCG_IDX_PDM_DIVISOR;
    localparam [31:0] FULL_RC   = `PCG_IDX_RC_DIV;
    localparam [31:0] FULL_USB  = `PCG_IDX_USB_PAD;
    localparam [7:0]  IDX_PER   = FULL_PER[7:0];
    localparam [7:0]  IDX_PCM   = FULL_PCM[7:0];
    localparam [7:0]  IDX_FRAC  = FULL_FRAC[7:0];
    localparam [7:0]  IDX_PDM   = FULL_PDM[7:0];
    localparam [7:0]  IDX_RC    = FULL_RC[7:0];
    localparam [7:0]  IDX_USB   = FULL_USB[7:0];

    assign idx    = paddr[9:2];
    assign access = psel & penable & ~pready;
    assign wr_en  = psel & penable & pready & pwrite & ~pslverr;
    assign wd     = pwdata[15:0];

    // Address decode and read mux
    always @* begin
        hit    = 1'b1;
        rd_val = 16'h0000;
        case (idx)
            IDX_PER:  rd_val = per_q;
            IDX_PCM:  rd_val = pcm_div_q;
            IDX_FRAC: rd_val = pcm_frac_q;
            IDX_PDM:  rd_val = pdm_divisor_q;
            IDX_RC:   rd_val = rc_div_q;
            IDX_USB:  rd_val = usb_q;
            default:  hit = 1'b0;
        endcase
    end

    // One wait state; answer registered
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (access) begin
            pready  <= 1'b1;
            pslverr <= ~hit;
            prdata  <= pwrite ? 32'h00000000 : {16'h0000, rd_val};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Register writes take effect at the completing edge
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            per_q      <= `PCG_RST_VALUE;
            pcm_div_q  <= `PCG_RST_VALUE;
            pcm_frac_q <= `PCG_RST_VALUE;
            pdm_divisor_q  <= `PCG_RST_VALUE;
            rc_div_q   <= `PCG_RST_VALUE;
            usb_q      <= `PCG_RST_VALUE;
        end else if (wr_en) begin
            case (idx)
                IDX_PER:
                    per_q <= wd & `PCG_MASK_PER_SEL_GATE;
                IDX_PCM:
                    pcm_div_q <= wd & `PCG_MASK_PCM_DIV;
                IDX_FRAC:
                    pcm_frac_q <= wd & `PCG_MASK_PCM_FRAC;
                IDX_PDM:
                    pdm_divisor_q <= wd & `PCG_MASK_PDM_DIVISOR;
                IDX_RC:
                    rc_div_q <= wd & `PCG_MASK_RC_DIV;
                IDX_USB:
                    usb_q <= wd & `PCG_MASK_USB_PAD;
                default: ;
            endcase
        end
    end

    // Source selection for adc, keyscan, i2c, spi
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_sel
            assign sel_tick[g] = per_q[`PCG_SEL_LSB + g] ?
                                 full_rate_tick : divided_tick;
        end
    endgenerate

    // Order: uart, spi, i2c, quad, infrared, keyscan
    assign src_tick = {sel_tick[2], divided_tick, divided_tick,
                       sel_tick[1], sel_tick[0], divided_tick};

    generate
        for (g = 0; g < 6; g = g + 1) begin : g_gate
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    periph_tick[g] <= 1'b0;
                end else begin
                    periph_tick[g] <= src_tick[g] &
                                      per_q[`PCG_GATE_LSB + g];
                end
            end
        end
    endgenerate

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            adc_tick <= 1'b0;
        end else begin
            adc_tick <= sel_tick[3];
        end
    end

    assign pcm_tick = pcm_div_q[`PCG_PCM_SRC_BIT] ?
                      full_rate_tick : divided_tick;

    pcg_clkdiv #(.DW(12), .FW(16)) u_pcm (
        .clk   (clk),
        .rstn  (rstn),
        .en    (pcm_div_q[`PCG_PCM_EN_BIT]),
        .tick  (pcm_tick),
        .div   (pcm_div_q[`PCG_PCM_DIV_MSB:0]),
        .frac  (pcm_frac_q),
        .clk_q (pcm_clk)
    );

    pcg_clkdiv #(.DW(8), .FW(16)) u_pdm (
        .clk   (clk),
        .rstn  (rstn),
        .en    (pdm_divisor_q[`PCG_DIV8_EN_BIT]),
        .tick  (divided_tick),
        .div   (pdm_divisor_q[`PCG_DIV8_MSB:0]),
        .frac  (16'h0000),
        .clk_q (pdm_clk)
    );

    pcg_clkdiv #(.DW(8), .FW(16)) u_rc (
        .clk   (clk),
        .rstn  (rstn),
        .en    (rc_div_q[`PCG_DIV8_EN_BIT]),
        .tick  (divided_tick),
        .div   (rc_div_q[`PCG_DIV8_MSB:0]),
        .frac  (16'h0000),
        .clk_q (rate_converter_clk)
    );

    // PDM role and USB pad controls
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pdm_role_select <= 1'b0;
            usb_pad_power   <= 1'b0;
            pullup_switch_a <= 1'b0;
            pullup_switch_b <= 1'b0;
        end else begin
            pdm_role_select <= pdm_divisor_q[`PCG_PDM_ROLE_BIT];
            usb_pad_power   <= usb_q[`PCG_USB_PWR_BIT] | usb_enabled;
            pullup_switch_a <= ~usb_q[`PCG_USB_A_OFF_BIT] &
                               usb_enabled & usb_ctrl_pullup_a;
            pullup_switch_b <= usb_q[`PCG_USB_B_ON_BIT] |
                               (usb_enabled & usb_ctrl_pullup_b);
        end
    end
endmodule // pcg_top
`default_nettype wire

// *** pcg_tmp_unused.v ***
`timescale 1ns/1ns

// *** pcg_properties.sv ***
// Port assertions of the clock generator
`timescale 1ns/1ns
`default_nettype none
module pcg_properties (
    // Clock, reset, bus answer
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       pready,
    // Ticks and clocks
    input wire logic       full_rate_tick,
    input wire logic       divided_tick,
    input wire logic [5:0] periph_tick,
    input wire logic       pcm_clk,
    input wire logic       pdm_clk,
    input wire logic       rate_converter_clk,
    // USB
    input wire logic       usb_enabled,
    input wire logic       usb_ctrl_pullup_b,
    input wire logic       usb_pad_power,
    input wire logic       pullup_switch_a,
    input wire logic       pullup_switch_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_uart_source: assert property (periph_tick[0]
        |-> $past(divided_tick)) else $error("uart tick");
    a_pcm_edges: assert property ($changed(pcm_clk)
        |-> $past(full_rate_tick) || $past(divided_tick))
        else $error("pcm edge");
    a_pdm_edges: assert property ($changed(pdm_clk)
        |-> $past(divided_tick)) else $error("pdm edge");
    a_rc_edges: assert property ($changed(rate_converter_clk)
        |-> $past(divided_tick)) else $error("rc edge");
    a_pad_power: assert property (usb_enabled
        |=> usb_pad_power) else $error("pad power");
    a_pullup_a: assert property (!usb_enabled
        |=> !pullup_switch_a) else $error("pullup a");
    a_pullup_b: assert property (usb_enabled && usb_ctrl_pullup_b
        |=> pullup_switch_b) else $error("pullup b");
    c_pcm: cover property ($rose(pcm_clk));
    c_pdm: cover property ($rose(pdm_clk));
    c_rc: cover property ($rose(rate_converter_clk));
endmodule // pcg_properties
bind pcg_top pcg_properties u_pcg_properties (.clk, .rstn, .pready,
    .full_rate_tick, .divided_tick, .periph_tick, .pcm_clk, .pdm_clk,
    .rate_converter_clk, .usb_enabled, .usb_ctrl_pullup_b,
    .usb_pad_power, .pullup_switch_a, .pullup_switch_b);
`default_nettype wire

// *** pcg_periph_model.sv ***
// Peripheral side: measures half periods of a clock in source ticks
`timescale 1ns/1ns
`default_nettype none
module pcg_periph_model (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Observed clock and its source
    input wire logic        tick,
    input wire logic        gen_clk,
    // Latest two half periods
    output var logic [15:0] half_q,
    output var logic [15:0] prev_q
);
    logic [15:0] cnt_q;
    logic        last_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {cnt_q, half_q, prev_q, last_q} <= '0;
        end else begin
            last_q <= gen_clk;
            cnt_q <= (gen_clk != last_q) ? 16'(tick) : cnt_q + 16'(tick);
            if (gen_clk != last_q) begin
                half_q <= cnt_q;
                prev_q <= half_q;
            end
        end
    end
endmodule // pcg_periph_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the clock generator
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        frt = 0, dvt = 0, ue = 0, pa = 0, pb = 0, clr = 1;
    logic        pready, pslverr, er, pcm, pdm, rcc, role, ps, sa, sb, adc;
    logic [7:0]  acnt;
    logic [1:0]  sel = 0;
    logic [5:0]  pt, u;
    logic [7:0]  pcnt [6];
    logic [15:0] half, prev;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd, rnd = 32'hcf3cef86;
    logic [31:0] tk = 32'hcf3cef86;
    int          num_errors = 0, checked = 0;
    localparam logic [31:0] adr [6] = '{32'h10, 32'h100, 32'h108,
        32'h110, 32'h118, 32'h128};
    localparam logic [15:0] msk [6] = '{16'h0f3f, 16'h3fff, 16'hffff,
        16'h03ff, 16'h01ff, 16'h0007};
    // Model select, byte address, write data, expected two-half sum
    localparam logic [39:0] ck [5] = '{40'h0_100_3002_04,
        40'h0_108_0002_05, 40'h1_110_0303_06, 40'h2_118_0100_02,
        40'h2_118_0108_10};
    pcg_top u_pcg_top (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .full_rate_tick(frt),
        .divided_tick(dvt), .periph_tick(pt), .adc_tick(adc), .pcm_clk(pcm),
        .pdm_clk(pdm), .rate_converter_clk(rcc), .pdm_role_select(role),
        .usb_enabled(ue), .usb_ctrl_pullup_a(pa), .usb_ctrl_pullup_b(pb),
        .usb_pad_power(ps), .pullup_switch_a(sa), .pullup_switch_b(sb));
    pcg_periph_model u_pcg_periph_model (.clk, .rstn, .half_q(half),
        .prev_q(prev), .tick(sel == 0 ? frt : dvt),
        .gen_clk(sel == 0 ? pcm : sel == 1 ? pdm : rcc));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    always #2 clk = ~clk;
    always @(posedge clk) begin
        tk <= lfsr(tk);
        frt <= tk[3];
        dvt <= tk[9];
        acnt <= clr ? 8'h00 : acnt + {7'h00, adc};
        for (int i = 0; i < 6; i++)
            pcnt[i] <= clr ? 8'h00 : pcnt[i] + {7'h00, pt[i]};
    end
    task automatic chk(input string s, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 9);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) begin
            num_errors++;
            conclude();
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            apb(0, adr[i], 0);
            chk("reset value", 0, rd);
            apb(1, adr[i], rnd);
            apb(0, adr[i], 0);
            chk("read back", rnd & msk[i], rd);
            apb(1, adr[i], 0);
        end
        apb(1, 32'h20, 1);
        chk("unmapped", 1, er);
        $display("test registers done");
        repeat (4) begin
            rnd = lfsr(rnd);
            apb(1, 32'h10, rnd);
            clr <= 1'b1;
            repeat (2) @(posedge clk);
            clr <= 1'b0;
            repeat (60) @(posedge clk);
            for (int i = 0; i < 6; i++)
                chk("gate", rnd[i], pcnt[i] != 0);
            chk("adc ticks", 1, acnt != 0);
        end
        $display("test gates done");
        foreach (ck[c]) begin
            sel <= ck[c][37:36];
            apb(1, {20'h0, ck[c][35:24]}, {16'h0, ck[c][23:8]});
            repeat (90) @(posedge clk);
            chk("half periods", ck[c][7:0], half + prev);
        end
        chk("role", 1, role);
        apb(1, 32'h110, 0);
        repeat (40) @(posedge clk);
        chk("pdm idle", 0, {pdm, role});
        $display("test clocks done");
        for (int i = 0; i < 64; i++) begin
            u = i[5:0];
            apb(1, 32'h128, {29'h0, u[2:0]});
            {ue, pa, pb} <= u[5:3];
            repeat (2) @(posedge clk);
            chk("usb pads",
                {u[0] | u[5], ~u[1] & u[5] & u[4], u[2] | u[5] & u[3]},
                {ps, sa, sb});
        end
        $display("test usb done");
        conclude();
    end
    initial begin
        #40000;
        num_errors++;
        conclude();
    end
endmodule // tb
`default_nettype wire
